// ---- verilog/rgb_backlight_consts.vh ----
`ifndef RGB_BACKLIGHT_CONSTS_VH
`define RGB_BACKLIGHT_CONSTS_VH
// register indices on the parallel register port
`define RBL_ADDR_RGB_CTRL    8'h00
`define RBL_ADDR_CUR_R       8'h01
`define RBL_ADDR_CUR_G       8'h02
`define RBL_ADDR_CUR_B       8'h03
`define RBL_ADDR_BRIGHT      8'h05
`define RBL_ADDR_VOLT        8'h0d
`define RBL_ADDR_CTRL        8'h06
`define RBL_ADDR_CORR_R      8'h0a
`define RBL_ADDR_CORR_G      8'h0b
`define RBL_ADDR_CORR_B      8'h0c
// rgb control fields
`define RBL_BIT_AUTO         3
`define RBL_BIT_FADE         5
`define RBL_BIT_SEQ0         6
`define RBL_BIT_SEQ1         7
// converter and sensor control fields
`define RBL_BIT_EN_BOOST     1
`define RBL_BIT_VOUT_AUTO    2
`define RBL_BIT_COMP_SEL     4
// reset values
`define RBL_RST_CTRL         8'h04
`define RBL_RST_VOLT         8'h05
`define RBL_RST_CORR         8'h80
`define RBL_RST_ZERO         8'h00
// boost limits in volts
`define RBL_VMIN             5'd5
`define RBL_VMAX             5'd20
// soft start time in ms and clock rate in kHz
`define RBL_SOFT_MS          50
`define RBL_CLK_KHZ          20000
`define RBL_SOFT_CYC         (`RBL_SOFT_MS * `RBL_CLK_KHZ)
// headroom windows in mV
`define RBL_HR_LO_SMALL      12'd850
`define RBL_HR_HI_SMALL      12'd1350
`define RBL_HR_LO_BIG        12'd1000
`define RBL_HR_HI_BIG        12'd1500
// current code giving 30 mA (code x 0.235 mA)
`define RBL_CUR_30MA         8'd128
// calibration layout: 11 pwm points per colour, then currents, sensor data
`define RBL_CAL_POINTS       11
`define RBL_CAL_CUR_BASE     6'd33
`define RBL_CAL_SENS_OFS     6'd36
`define RBL_CAL_SENS_GAIN    6'd37
`define RBL_CAL_HEAT         6'd38
`define RBL_CAL_WORDS        64
`endif

// ---- verilog/rgb_backlight_mode_boost_ctrl.v ----
// Functional notes
// [R1] boost enable low puts converter in standby
// [R2] enable high: 50 ms low current, then normal
// [R3] manual mode: target volts equals written code
// [R4] codes below five are used as five
// [R5] codes above twenty are used as twenty
// [R6] adaptive bit set ignores programmed voltage code
// [R7] adaptive keeps lowest driver in headroom window
// [R8] adaptive voltage stays between five and twenty
// [R9] adaptive after reset, forced in stand-alone
// [R10] mode from auto bit and sequence bits
// [R11] manual: no internal pwm, constant register current
// [R12] manual: external gate pin gates each colour
// [R13] manual: no log brightness, compensation, fade, sequence
// [R14] auto: interpolate 12-bit pwm on 16 degree points
// [R15] sensor result mapped to calibration address
// [R16] compensation channel chosen by select bit
// [R17] auto: currents come from calibration memory
// [R18] common 3-bit logarithmic brightness for all colours
// [R19] pwm times per-colour correction, zero to two
// [R20] temperature shifted by red-pwm scaled self-heat
// [R21] sequential: gate pulse starts new output sequence
// [R22] fading scales all colours together
// [R23] bit 4 selects compensation sensor channel
// [R24] bit 1 of control enables the boost
// [R25] bit 2 of control selects adaptive voltage
`timescale 1ns/1ps
`include "rgb_backlight_consts.vh"
module rgb_backlight_mode_boost_ctrl #(
  parameter SOFT_CYC = `RBL_SOFT_CYC
) (
  // clock and reset
  input  wire        sys_clk,
  input  wire        resetn,
  // register port from the serial interface
  input  wire        reg_wr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // stand-alone mode indication from the brightness input decoder
  input  wire        standalone,
  // external gate pins, asynchronous
  input  wire        red_external_gate,
  input  wire        green_external_gate,
  input  wire        blue_external_gate,
  // sensor conversion results and driver headroom in mV
  input  wire [11:0] first_sensor_input,
  input  wire [11:0] second_sensor_input,
  input  wire [11:0] min_driver_mv,
  // calibration memory write port
  input  wire        cal_wr,
  input  wire [5:0]  cal_addr,
  input  wire [11:0] cal_wdata,
  // boost converter control
  output reg         boost_run,
  output reg         boost_low_current,
  output reg  [4:0]  boost_volts,
  // led drive
  output reg  [23:0] led_current,
  output reg  [35:0] led_pwm,
  output reg  [2:0]  led_gate,
  output reg         pwm_internal,
  output reg  [2:0]  seq_start,
  output reg  [1:0]  op_mode
);

  // op_mode codes; the three sequential pulse counts share one code,
  // the pulse count itself belongs to the drive stage downstream
  // a cleared auto bit with a nonzero sequence field has no mode of
  // its own; it falls back to manual so that the pins keep gating
  localparam MODE_MANUAL = 2'd0;
  localparam MODE_AUTO   = 2'd1;
  localparam MODE_SEQ    = 2'd2;

  // converter sequencing: off (standby), soft start, normal switching
  // soft start is a fixed time, not a voltage threshold, so it cannot
  // hang on a converter that never reaches its target
  // the unused fourth code falls back to standby
  localparam BST_OFF  = 2'd0;
  localparam BST_SOFT = 2'd1;
  localparam BST_RUN  = 2'd2;

  // register copies; current and correction bytes are packed {b,g,r}
  // so that the per-colour generate below can slice them by index
  // calibration words are 12 bits wide; current codes use the low byte
  // of their word, the upper bits of those words are ignored
  reg [7:0]  rgb_ctrl_r;
  reg [7:0]  ctrl_r;
  reg [7:0]  volt_r;
  reg [7:0]  bright_r;
  reg [23:0] cur_r;
  reg [23:0] corr_r;
  reg [11:0] cal_mem [0:`RBL_CAL_WORDS-1];

  wire       auto_bit  = rgb_ctrl_r[`RBL_BIT_AUTO];
  wire [1:0] seq_bits  = {rgb_ctrl_r[`RBL_BIT_SEQ1], rgb_ctrl_r[`RBL_BIT_SEQ0]};
  wire       fade_en   = rgb_ctrl_r[`RBL_BIT_FADE];
  wire       en_boost  = ctrl_r[`RBL_BIT_EN_BOOST];     // [R24]
  wire       vout_auto = ctrl_r[`RBL_BIT_VOUT_AUTO] | standalone; // [R25] [R9]
  wire       comp_sel  = ctrl_r[`RBL_BIT_COMP_SEL];     // [R23]

  // registers
  // writes to unmapped indices fall through the default and are lost
  // the voltage code is kept as written; clamping happens downstream
  // so that a later change of the limits needs no register change
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rgb_ctrl_r <= `RBL_RST_ZERO;
      ctrl_r     <= `RBL_RST_CTRL; // [R9]
      volt_r     <= `RBL_RST_VOLT;
      bright_r   <= `RBL_RST_ZERO;
      cur_r      <= 24'h000000;
      corr_r     <= {3{`RBL_RST_CORR}};
    end else if (reg_wr) begin
      case (reg_addr)
        `RBL_ADDR_RGB_CTRL: rgb_ctrl_r <= reg_wdata;
        `RBL_ADDR_CUR_R:    cur_r[7:0] <= reg_wdata;
        `RBL_ADDR_CUR_G:    cur_r[15:8] <= reg_wdata;
        `RBL_ADDR_CUR_B:    cur_r[23:16] <= reg_wdata;
        `RBL_ADDR_BRIGHT:   bright_r <= reg_wdata;
        `RBL_ADDR_VOLT:     volt_r <= reg_wdata;
        `RBL_ADDR_CTRL:     ctrl_r <= reg_wdata;
        `RBL_ADDR_CORR_R:   corr_r[7:0] <= reg_wdata;
        `RBL_ADDR_CORR_G:   corr_r[15:8] <= reg_wdata;
        `RBL_ADDR_CORR_B:   corr_r[23:16] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // calibration store has no reset: its contents are loaded by the
  // production write port and must survive a register reset
  // limitation: a write during auto mode changes the lookup at once,
  // so the host should load the store with the outputs in manual
  always @(posedge sys_clk) begin
    if (cal_wr)
      cal_mem[cal_addr] <= cal_wdata;
  end

  // read port is combinational on the index; the voltage entry returns
  // the clamped or adaptive value actually commanded, not the raw code
  // unmapped indices read as zero
  always @* begin
    case (reg_addr)
      `RBL_ADDR_RGB_CTRL: reg_rdata = rgb_ctrl_r;
      `RBL_ADDR_CUR_R:    reg_rdata = cur_r[7:0];
      `RBL_ADDR_CUR_G:    reg_rdata = cur_r[15:8];
      `RBL_ADDR_CUR_B:    reg_rdata = cur_r[23:16];
      `RBL_ADDR_BRIGHT:   reg_rdata = bright_r;
      `RBL_ADDR_VOLT:     reg_rdata = {3'b000, boost_volts};
      `RBL_ADDR_CTRL:     reg_rdata = ctrl_r;
      `RBL_ADDR_CORR_R:   reg_rdata = corr_r[7:0];
      `RBL_ADDR_CORR_G:   reg_rdata = corr_r[15:8];
      `RBL_ADDR_CORR_B:   reg_rdata = corr_r[23:16];
      default:            reg_rdata = 8'h00;
    endcase
  end

  // operating mode decode; auto 0 with nonzero sequence is treated as manual
  // mode_nxt is used directly inside the block so that drive and
  // compensation switch together with op_mode on the same edge
  reg [1:0] mode_nxt;
  always @* begin
    case ({auto_bit, seq_bits == 2'b00})
      2'b11:   mode_nxt = MODE_AUTO;  // [R10]
      2'b10:   mode_nxt = MODE_SEQ;   // [R10]
      default: mode_nxt = MODE_MANUAL; // [R10]
    endcase
  end

  // gate pin synchronisers and edge detect, one slice per colour
  // reset to the idle high level of unused pins, so that leaving
  // reset never looks like a rising edge to the sequence trigger
  reg [2:0]  gate_s1_r;
  reg [2:0]  gate_s2_r;
  reg [2:0]  gate_d_r;
  wire [2:0] gate_pin = {blue_external_gate, green_external_gate,
                         red_external_gate};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : sync
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          gate_s1_r[g] <= 1'b1;
          gate_s2_r[g] <= 1'b1;
          gate_d_r[g]  <= 1'b1;
        end else begin
          gate_s1_r[g] <= gate_pin[g];
          gate_s2_r[g] <= gate_s1_r[g];
          gate_d_r[g]  <= gate_s2_r[g];
        end
      end
    end
  endgenerate

  // boost sequencing
  // a clear of the enable bit always wins over the soft start count,
  // and a new set of the bit restarts the full low-current phase
  // the counter is wide enough for the full time at the real clock
  reg [1:0]  bst_r;
  reg [25:0] soft_cnt_r;
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bst_r      <= BST_OFF;
      soft_cnt_r <= 26'd0;
    end else begin
      case (bst_r)
        BST_OFF: begin
          soft_cnt_r <= 26'd0;
          if (en_boost)
            bst_r <= BST_SOFT; // [R2]
        end
        BST_SOFT: begin
          soft_cnt_r <= soft_cnt_r + 26'd1;
          if (!en_boost)
            bst_r <= BST_OFF; // [R1]
          else if (soft_cnt_r == SOFT_CYC - 1)
            bst_r <= BST_RUN; // [R2]
        end
        BST_RUN: begin
          if (!en_boost)
            bst_r <= BST_OFF; // [R1]
        end
        default: bst_r <= BST_OFF;
      endcase
    end
  end

  // manual voltage clamp
  // codes outside the span are saturated, never wrapped, so a stray
  // write cannot command more than the top of the converter range
  reg [4:0] man_volts;
  always @* begin
    if (volt_r < {3'b000, `RBL_VMIN})
      man_volts = `RBL_VMIN; // [R4]
    else if (volt_r > {3'b000, `RBL_VMAX})
      man_volts = `RBL_VMAX; // [R5]
    else
      man_volts = volt_r[4:0]; // [R3]
  end

  // adaptive loop: one volt step per tick of the headroom window check
  // the slow tick lets the converter output settle between steps;
  // a window rather than a single threshold avoids hunting
  // the loop still runs while manual voltage is selected, so a
  // switch to adaptive starts from its last value
  reg [4:0]  adapt_r;
  reg [15:0] adapt_tick_r;
  wire [23:0] cur_used;
  wire big_cur = (cur_used[7:0] > `RBL_CUR_30MA) |
                 (cur_used[15:8] > `RBL_CUR_30MA) |
                 (cur_used[23:16] > `RBL_CUR_30MA);
  wire [11:0] hr_lo = big_cur ? `RBL_HR_LO_BIG : `RBL_HR_LO_SMALL; // [R7]
  wire [11:0] hr_hi = big_cur ? `RBL_HR_HI_BIG : `RBL_HR_HI_SMALL; // [R7]
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      adapt_r      <= `RBL_VMIN;
      adapt_tick_r <= 16'd0;
    end else begin
      adapt_tick_r <= adapt_tick_r + 16'd1;
      if (adapt_tick_r == 16'hffff) begin
        if (min_driver_mv < hr_lo && adapt_r < `RBL_VMAX)
          adapt_r <= adapt_r + 5'd1; // [R7] [R8]
        else if (min_driver_mv > hr_hi && adapt_r > `RBL_VMIN)
          adapt_r <= adapt_r - 5'd1; // [R7] [R8]
      end
    end
  end

  // compensation: sensor select, self-heat, address, interpolation
  // the sensor reading is shifted by the self-heating estimate before
  // it is scaled into a table position; the registered red pwm is
  // used, which breaks the loop through the interpolator
  wire [11:0] sens = comp_sel ? second_sensor_input
                              : first_sensor_input; // [R16]
  reg  [11:0] red_pwm_r;
  wire [23:0] heat_prod = cal_mem[`RBL_CAL_HEAT] * red_pwm_r;
  wire [12:0] sens_adj  = {1'b0, sens} + {1'b0, heat_prod[23:12]}; // [R20]
  wire [12:0] sens_ofs  = (sens_adj > {1'b0, cal_mem[`RBL_CAL_SENS_OFS]}) ?
                          sens_adj - {1'b0, cal_mem[`RBL_CAL_SENS_OFS]} :
                          13'd0;
  wire [24:0] tpos_full = sens_ofs * cal_mem[`RBL_CAL_SENS_GAIN]; // [R15]
  // tpos: integer part indexes the 16 degree points, low 4 bits interpolate
  wire [7:0]  tpos = (tpos_full[24:16] > 9'd159) ? 8'd159
                                                 : tpos_full[23:16];
  wire [3:0]  seg  = tpos[7:4];
  wire [3:0]  frac = tpos[3:0];

  // one slice per colour: table lookup, correction, brightness, fade
  // corr values are fixed point with 8'h80 as unity, 8'hff just
  // under two; the product saturates instead of wrapping
  // position 159 is the last one whose upper neighbour exists
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : col
      wire [11:0] p0 = cal_mem[c * `RBL_CAL_POINTS + seg];     // [R14]
      wire [11:0] p1 = cal_mem[c * `RBL_CAL_POINTS + seg + 1]; // [R14]
      wire [16:0] interp = ({p0, 4'h0} + frac * p1 - frac * p0); // [R14]
      wire [19:0] corr_p = interp[15:4] * corr_r[c*8 +: 8];    // [R19]
      wire [12:0] corr_s = corr_p[19:7];
      wire [11:0] corr_c = corr_s[12] ? 12'hfff : corr_s[11:0];
      // 3-bit level halves per step below the top
      wire [11:0] bright = corr_c >> (3'd7 - bright_r[2:0]);   // [R18]
      assign cur_used[c*8 +: 8] = (mode_nxt == MODE_MANUAL) ?
        cur_r[c*8 +: 8] :                                      // [R11]
        cal_mem[`RBL_CAL_CUR_BASE + c][7:0];                   // [R17]
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          led_pwm[c*12 +: 12] <= 12'h000;
        end else if (mode_nxt == MODE_MANUAL) begin
          led_pwm[c*12 +: 12] <= 12'h000; // [R13]
        end else if (fade_en) begin
          // one common step of one count per clock; each colour stops at its own target
          if (led_pwm[c*12 +: 12] < bright)
            led_pwm[c*12 +: 12] <= led_pwm[c*12 +: 12] + 12'd1; // [R22]
          else if (led_pwm[c*12 +: 12] > bright)
            led_pwm[c*12 +: 12] <= led_pwm[c*12 +: 12] - 12'd1; // [R22]
        end else begin
          led_pwm[c*12 +: 12] <= bright;
        end
      end
    end
  endgenerate

  // outputs
  // every output but reg_rdata is registered; op_mode and the drive outputs
  // change on the same edge, so no consumer sees a mixed state
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boost_run         <= 1'b0;
      boost_low_current <= 1'b0;
      boost_volts       <= `RBL_VMIN;
      led_current       <= 24'h000000;
      led_gate          <= 3'b000;
      pwm_internal      <= 1'b0;
      seq_start         <= 3'b000;
      op_mode           <= MODE_MANUAL;
      red_pwm_r         <= 12'h000;
    end else begin
      boost_run         <= (bst_r != BST_OFF); // [R1]
      boost_low_current <= (bst_r == BST_SOFT); // [R2]
      boost_volts       <= vout_auto ? adapt_r : man_volts; // [R6] [R8]
      led_current       <= cur_used;
      op_mode           <= mode_nxt;
      red_pwm_r         <= led_pwm[11:0];
      pwm_internal      <= (mode_nxt != MODE_MANUAL); // [R11]
      led_gate          <= (mode_nxt == MODE_SEQ) ? 3'b111
                                                  : gate_s2_r; // [R12]
      seq_start         <= (mode_nxt == MODE_SEQ) ?
                           (gate_s2_r & ~gate_d_r) : 3'b000; // [R21]
    end
  end

endmodule // rgb_backlight_mode_boost_ctrl

// ---- dv/rgb_backlight_props.sv ----
`timescale 1ns/1ps
module rgb_backlight_props #(
  parameter SOFT_CYC = 100
) (
  // clock, reset and register port
  input wire       sys_clk,
  input wire       resetn,
  input wire       reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  // gate pins
  input wire       red_external_gate,
  input wire       green_external_gate,
  input wire       blue_external_gate,
  // watched outputs
  input wire       boost_run,
  input wire       boost_low_current,
  input wire [4:0] boost_volts,
  input wire [2:0] led_gate,
  input wire       pwm_internal,
  input wire [2:0] seq_start,
  input wire [1:0] op_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire [2:0]  pins;
  reg  [1:0]  exp_mode_r;
  reg  [31:0] soft_cnt_r;
  assign pins = {blue_external_gate, green_external_gate, red_external_gate};
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      exp_mode_r <= 2'h0;
      soft_cnt_r <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h00)
        exp_mode_r <= !reg_wdata[3] ? 2'h0 :
                      (reg_wdata[7:6] == 2'h0 ? 2'h1 : 2'h2);
      soft_cnt_r <= boost_low_current ? soft_cnt_r + 32'h1 : 32'h0;
    end
  end
  sequence mode_wr; reg_wr && reg_addr == 8'h00; endsequence
  sequence calm; !(reg_wr && reg_addr == 8'h00); endsequence
  sequence off_wr; reg_wr && reg_addr == 8'h06 && !reg_wdata[1]; endsequence
  a_mode_decode: assert property (
    mode_wr ##1 calm |=> op_mode == exp_mode_r) else $error("bad mode");
  a_boost_off: assert property (
    off_wr |=> ##2 !boost_run) else $error("boost not in standby");
  a_soft_start: assert property (
    $rose(boost_run) |-> boost_low_current [*4]) else $error("no soft start");
  a_soft_len: assert property (
    soft_cnt_r <= SOFT_CYC + 2) else $error("soft start too long");
  a_volt_span: assert property (
    boost_volts >= 5'd5 && boost_volts <= 5'd20) else $error("volts out");
  a_manual_dc: assert property (
    op_mode == 2'h0 && $past(op_mode) == 2'h0 |->
    !pwm_internal && seq_start == 3'h0) else $error("manual not dc");
  a_gate_follow: assert property (
    $past(resetn, 3) && op_mode != 2'h2 && $past(op_mode, 3) != 2'h2 |->
    led_gate == $past(pins, 3)) else $error("gate not followed");
  a_seq_gate: assert property (
    op_mode == 2'h2 && $past(op_mode) == 2'h2 |-> led_gate == 3'h7)
    else $error("seq gate not open");
  a_seq_pulse: assert property (
    seq_start != 3'h0 |=> seq_start == 3'h0) else $error("long seq pulse");
endmodule // rgb_backlight_props
bind rgb_backlight_mode_boost_ctrl rgb_backlight_props #(
  .SOFT_CYC(SOFT_CYC)
) props_u (.sys_clk, .resetn, .reg_wr, .reg_addr, .reg_wdata,
  .red_external_gate, .green_external_gate, .blue_external_gate,
  .boost_run, .boost_low_current, .boost_volts, .led_gate,
  .pwm_internal, .seq_start, .op_mode);

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire       sys_clk,
  // register port
  output reg        reg_wr,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata,
  // gate pins
  output reg  [2:0] gates
);
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 8'h00;
    gates = 3'h7;
  end
  // data turned over after the strobe so a stale byte never looks valid
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge sys_clk);
      reg_addr = a;
      #10 d = reg_rdata;
    end
  endtask
  task set_gates(input [2:0] g);
    begin
      @(negedge sys_clk);
      gates = g;
    end
  endtask
endmodule // host_model

// ---- dv/rgb_backlight_mode_boost_ctrl_tb.sv ----
`timescale 1ns/1ps
module rgb_backlight_mode_boost_ctrl_tb;
  localparam SOFT = 100;
  reg         sys_clk, resetn, standalone, cal_wr;
  reg  [5:0]  cal_addr;
  reg  [11:0] cal_wdata, s1, s2, mv;
  wire        reg_wr, boost_run, boost_low_current, pwm_internal;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata;
  wire [2:0]  gates, led_gate, seq_start;
  wire [4:0]  boost_volts;
  wire [23:0] led_current;
  wire [35:0] led_pwm;
  wire [1:0]  op_mode;
  int         fail_count, num_checks, i, n, e, mdl[256], cm[64];
  int         ra[8] = '{6, 13, 10, 11, 12, 5, 1, 32};
  reg  [7:0]  d;
  reg  [4:0]  v;
  host_model host_u (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .gates(gates));
  rgb_backlight_mode_boost_ctrl #(.SOFT_CYC(SOFT)) dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .standalone(standalone), .red_external_gate(gates[0]),
    .green_external_gate(gates[1]), .blue_external_gate(gates[2]),
    .first_sensor_input(s1), .second_sensor_input(s2),
    .min_driver_mv(mv), .cal_wr(cal_wr), .cal_addr(cal_addr),
    .cal_wdata(cal_wdata), .boost_run(boost_run),
    .boost_low_current(boost_low_current), .boost_volts(boost_volts),
    .led_current(led_current), .led_pwm(led_pwm), .led_gate(led_gate),
    .pwm_internal(pwm_internal), .seq_start(seq_start), .op_mode(op_mode));
  task chk(input bit ok, input string m);
    num_checks++;
    if (!ok) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wt(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  task rdchk(input [7:0] a);
    host_u.rd(a, d);
    chk(d === mdl[a][7:0], "read back mismatch");
  endtask
  function int clampv(input int c);
    return c < 5 ? 5 : (c > 20 ? 20 : c);
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    end_of_test;
  end
  initial begin
    {resetn, standalone, cal_wr, cal_addr, cal_wdata} = 0;
    {s1, s2} = 0;
    mv = 12'd1200;
    i = $urandom(14);
    mdl[6] = 4;
    mdl[13] = 5;
    for (i = 10; i < 13; i++) mdl[i] = 8'h80;
    wt(20);
    resetn = 1'b1;
    foreach (ra[k]) rdchk(ra[k]);
    chk(boost_volts === 5'd5 && boost_run === 1'b0, "reset outputs");
    for (i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      cm[i] = $urandom % 4096;
      {cal_wr, cal_addr, cal_wdata} = {1'b1, i[5:0], cm[i][11:0]};
    end
    @(negedge sys_clk);
    {cal_wr, s1, s2} = {1'b0, 12'($urandom), 12'($urandom)};
    host_u.wr(8'h06, 8'h02);
    mdl[6] = 2;
    wt(2);
    chk(boost_run === 1'b1 && boost_low_current === 1'b1, "no start");
    for (n = 0; boost_low_current === 1'b1 && n < SOFT + 10; n++) wt(1);
    chk(boost_low_current === 1'b0 && n >= SOFT - 3, "soft time");
    foreach (ra[k]) begin
      e = (ra[k] * 3) % 25;
      host_u.wr(8'h0d, e[7:0]);
      mdl[13] = clampv(e);
      wt(3);
      chk(boost_volts === mdl[13][4:0], "manual volts");
      rdchk(8'h0d);
    end
    for (i = 0; i < 2; i++) begin
      mdl[6] = i ? 8'h02 : 8'h16;
      host_u.wr(8'h06, mdl[6][7:0]);
      standalone = i[0];
      rdchk(8'h06);
      v = boost_volts;
      host_u.wr(8'h0d, v == 5'd20 ? 8'h05 : 8'h14);
      wt(3);
      chk(boost_volts === v, "code not ignored");
      for (n = 0; n < 300; n++) begin
        wt(1);
        mv = 12'($urandom % 2000);
      end
      if (i) begin
        mv = 12'd100;
        for (n = 0; boost_volts === v && n < 70000; n++) wt(1);
        chk(boost_volts === v + 5'd1, "no adaptive step");
      end
    end
    standalone = 1'b0;
    for (i = 0; i < 8; i++) begin
      host_u.wr(8'h00, {i[1:0], 2'b00, i[2], 3'b000});
      e = !i[2] ? 0 : (i[1:0] == 0 ? 1 : 2);
      wt(2);
      chk(op_mode === e[1:0], "mode decode");
      host_u.set_gates(3'($urandom));
      wt(4);
      chk(pwm_internal === (e != 0), "internal pwm");
      if (e != 0) chk(led_current[7:0] === cm[33][7:0], "cal cur");
      else chk(led_current === 24'h0 && led_pwm === 36'h0,
        "dc drive");
      if (e != 2) chk(led_gate === gates, "gate follow");
      else begin
        chk(led_gate === 3'h7, "seq gate open");
        host_u.set_gates(3'h0);
        wt(4);
        host_u.set_gates(3'h1);
        for (n = 0; seq_start[0] !== 1'b1 && n < 8; n++) wt(1);
        chk(n < 8, "no sequence start");
      end
    end
    for (i = 10; i < 13; i++) begin
      mdl[i] = $urandom % 256;
      host_u.wr(i[7:0], mdl[i][7:0]);
      rdchk(i[7:0]);
    end
    host_u.wr(8'h30, 8'h5a);
    rdchk(8'h30);
    host_u.wr(8'h06, 8'h00);
    wt(3);
    chk(boost_run === 1'b0 && boost_low_current === 1'b0, "standby");
    resetn = 1'b0;
    wt(2);
    resetn = 1'b1;
    mdl[6] = 4;
    rdchk(8'h06);
    chk(op_mode === 2'h0, "mode after reset");
    host_u.wr(8'h01, 8'h55);
    wt(3);
    chk(led_current === 24'h000055 && led_pwm === 36'h0, "man cur");
    end_of_test;
  end
endmodule // rgb_backlight_mode_boost_ctrl_tb
